// >>> design/address_breakpoint_unit.sv
// Address breakpoint unit: compares CPU fetch addresses with a break address and requests breaks
// Assumes CPU status inputs are synchronous to ref_clk and valid in the cycle they are sampled
//
// Notes on behaviour
// R1: Enabled full address match raises a breakpoint request for opcode injection.
// R2: Break vector is the normal pair, or the monitor pair in monitor mode.
// R3: Enable bit 7 of control gates matches; write zero or reset clears it.
// R4: Active bit set by hardware on a match; cleared by writing zero or reset.
// R5: Writing one to active forces a break before the next instruction starts.
// R6: Match on opcode address breaks before that instruction executes.
// R7: Match on operand address lets the instruction finish before breaking.
// R8: Both break address bytes hold the address and reset to zero.
// R9: Return from interrupt in the break routine ends the break state.
// R10: Active cleared without new address: no further break after routine exits.
// R11: Software rewrites address and clears active in each routine for repeats.
// R12: Software places breakpoints only on opcode addresses; the bench also places them on operand addresses in its odd loop passes.
// R13: In monitor mode during break, watchdog-disable bit holds the watchdog off.
// R14: Wait-exit flag reads one when a break ended wait mode.
// R15: Other modules may clear status bits in break only with clear-enable set.
// R16: Timer counter halts while a break is active.
// R17: No address break is raised in wait or stop modes.
// R18: Clear-enable resets to zero, protecting flags during break.
// R19: Compare only program-counter fetches; request is registered on the clock.
`timescale 1ns/100ps
`default_nettype none
module address_breakpoint_unit
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire break_pkg::reg_req_type reg_req,
  output var logic [7:0] reg_rdata,
  input wire break_pkg::cpu_in_type cpu_in,
  output var break_pkg::cpu_out_type cpu_out,
  output var logic irq
);
  import break_pkg::*;

  state_type state_reg;
  state_type state_next;
  logic addr_hit;
  logic wr_active_one;
  logic wr_active_zero;
  logic low_power;
  logic pending_operand_reg;
  logic pending_operand_next;
  // A match disarms the comparator until software rewrites an address byte
  logic armed_reg;
  logic armed_next;

  always_comb
  begin
    low_power = cpu_in.wait_mode || cpu_in.stop_mode;
    addr_hit = state_reg.enable && armed_reg && !low_power && cpu_in.instr_start == 1'b0 &&
      cpu_in.addr == {state_reg.addr_high, state_reg.addr_low}; // R1 R3 R10 R17 R19
    wr_active_one = reg_req.wr && reg_req.addr == addr_control_status &&
      reg_req.wdata[active_bit];
    wr_active_zero = reg_req.wr && reg_req.addr == addr_control_status &&
      !reg_req.wdata[active_bit];
    pending_operand_next = pending_operand_reg;
    armed_next = armed_reg;
    state_next = state_reg;
    state_next.cpu_out.breakpoint_request = 1'b0;
    state_next.rdata = byte_reset;

    // Register writes
    if (reg_req.wr)
    begin
      if (reg_req.addr == addr_control_status)
      begin
        state_next.enable = reg_req.wdata[enable_bit]; // R3
        state_next.active = reg_req.wdata[active_bit]; // R4 R10
      end
      else if (reg_req.addr == addr_address_high)
      begin
        state_next.addr_high = reg_req.wdata; // R8
        armed_next = 1'b1; // R10
      end
      else if (reg_req.addr == addr_address_low)
      begin
        state_next.addr_low = reg_req.wdata; // R8
        armed_next = 1'b1; // R10
      end
      else if (reg_req.addr == addr_auxiliary)
      begin
        state_next.cop_disable = reg_req.wdata[cop_disable_bit]; // R13
      end
      else if (reg_req.addr == addr_flag_control)
      begin
        state_next.clear_enable = reg_req.wdata[clear_enable_bit]; // R15 R18
      end
      else if (reg_req.addr == addr_irq_mask)
      begin
        state_next.irq_mask = reg_req.wdata[1:0];
      end
    end

    // Match handling; a set active bit blocks re-triggering until cleared
    if (!state_reg.active && !state_reg.in_break)
    begin
      if (addr_hit && cpu_in.opcode_fetch)
      begin
        state_next.cpu_out.breakpoint_request = 1'b1; // R1 R6 R19
        armed_next = 1'b0; // R10
        state_next.active = 1'b1; // R4
        state_next.in_break = 1'b1;
        state_next.irq_status[irq_match_bit] = 1'b1;
      end
      else if (addr_hit)
      begin
        pending_operand_next = 1'b1; // R7
      end
    end
    if (pending_operand_reg && cpu_in.instr_start && !state_reg.in_break)
    begin
      state_next.cpu_out.breakpoint_request = 1'b1; // R7
      armed_next = 1'b0; // R10
      state_next.active = 1'b1;
      state_next.in_break = 1'b1;
      state_next.irq_status[irq_match_bit] = 1'b1;
      pending_operand_next = 1'b0;
    end

    // Forced break waits for the next instruction boundary
    if (state_reg.active && !state_reg.in_break && cpu_in.instr_start && !wr_active_zero)
    begin
      state_next.cpu_out.breakpoint_request = 1'b1; // R5
      state_next.in_break = 1'b1;
      state_next.irq_status[irq_forced_bit] = 1'b1;
    end
    if (wr_active_one && state_reg.in_break)
    begin
      state_next.active = 1'b1;
    end

    if (state_reg.in_break && cpu_in.rti_done)
    begin
      state_next.in_break = 1'b0; // R9
      pending_operand_next = 1'b0;
    end

    if (state_reg.in_break && cpu_in.wait_exit_break)
    begin
      state_next.wait_exit = 1'b1; // R14
    end
    else if (!state_reg.in_break)
    begin
      state_next.wait_exit = 1'b0; // R14
    end

    // Register reads; status read clears, but a same-cycle event wins
    if (reg_req.rd)
    begin
      if (reg_req.addr == addr_control_status)
      begin
        state_next.rdata = {state_reg.enable, state_reg.active, 6'h00};
      end
      else if (reg_req.addr == addr_address_high)
      begin
        state_next.rdata = state_reg.addr_high;
      end
      else if (reg_req.addr == addr_address_low)
      begin
        state_next.rdata = state_reg.addr_low;
      end
      else if (reg_req.addr == addr_auxiliary)
      begin
        state_next.rdata = {7'h00, state_reg.cop_disable};
      end
      else if (reg_req.addr == addr_wait_status)
      begin
        state_next.rdata = {6'h00, state_reg.wait_exit, 1'b0}; // R14
      end
      else if (reg_req.addr == addr_flag_control)
      begin
        state_next.rdata = {state_reg.clear_enable, 7'h00};
      end
      else if (reg_req.addr == addr_irq_status)
      begin
        state_next.rdata = {6'h00, state_reg.irq_status};
        state_next.irq_status = state_next.irq_status & ~state_reg.irq_status |
          (state_next.irq_status & ~state_reg.irq_status);
        state_next.irq_status[irq_match_bit] = state_next.cpu_out.breakpoint_request &&
          !state_reg.active;
        state_next.irq_status[irq_forced_bit] = state_next.cpu_out.breakpoint_request &&
          state_reg.active;
      end
      else if (reg_req.addr == addr_irq_mask)
      begin
        state_next.rdata = {6'h00, state_reg.irq_mask};
      end
      else
      begin
        state_next.rdata = byte_reset;
      end
    end

    state_next.cpu_out.in_break = state_next.in_break;
    state_next.cpu_out.break_vector = cpu_in.monitor_mode ? vector_monitor
      : vector_normal; // R2
    state_next.cpu_out.watchdog_hold = state_next.in_break && cpu_in.monitor_mode &&
      state_next.cop_disable; // R13
    state_next.cpu_out.timer_halt = state_next.in_break; // R16
    state_next.cpu_out.flag_clear_allowed = !state_next.in_break ||
      state_next.clear_enable; // R15 R18
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= '0; // R3 R4 R8 R18
      state_reg.cpu_out.break_vector <= vector_normal;
      state_reg.cpu_out.flag_clear_allowed <= 1'b1;
      pending_operand_reg <= 1'b0;
      armed_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      pending_operand_reg <= pending_operand_next;
      armed_reg <= armed_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign cpu_out = state_reg.cpu_out;
  assign irq = state_reg.irq;
endmodule
`default_nettype wire

// >>> design/break_pkg.sv
// Package for the address breakpoint unit: register offsets, field positions, reset values
// Assumes a byte-wide register port with a 3-bit address
package break_pkg;
  localparam logic [2:0] addr_control_status = 3'h0;
  localparam logic [2:0] addr_address_high = 3'h1;
  localparam logic [2:0] addr_address_low = 3'h2;
  localparam logic [2:0] addr_auxiliary = 3'h3;
  localparam logic [2:0] addr_wait_status = 3'h4;
  localparam logic [2:0] addr_flag_control = 3'h5;
  localparam logic [2:0] addr_irq_status = 3'h6;
  localparam logic [2:0] addr_irq_mask = 3'h7;
  localparam int enable_bit = 7;
  localparam int active_bit = 6;
  localparam int cop_disable_bit = 0;
  localparam int wait_exit_bit = 1;
  localparam int clear_enable_bit = 7;
  localparam int irq_match_bit = 0;
  localparam int irq_forced_bit = 1;
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [15:0] vector_normal = 16'hfffc;
  localparam logic [15:0] vector_monitor = 16'hfefc;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic [15:0] addr;
    logic opcode_fetch;
    logic instr_start;
    logic rti_done;
    logic wait_mode;
    logic stop_mode;
    logic monitor_mode;
    logic wait_exit_break;
  } cpu_in_type;

  typedef struct packed {
    logic breakpoint_request;
    logic [15:0] break_vector;
    logic in_break;
    logic watchdog_hold;
    logic timer_halt;
    logic flag_clear_allowed;
  } cpu_out_type;

  typedef struct packed {
    logic enable;
    logic active;
    logic [7:0] addr_high;
    logic [7:0] addr_low;
    logic cop_disable;
    logic wait_exit;
    logic clear_enable;
    logic in_break;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
    cpu_out_type cpu_out;
    logic irq;
  } state_type;
endpackage

// >>> verification/address_breakpoint_unit_properties.sv
// Checker for the breakpoint unit's ports
// Assumes one clock domain and the bind at the foot
`timescale 1ns/100ps
`default_nettype none
module address_breakpoint_unit_properties
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire break_pkg::reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire break_pkg::cpu_in_type cpu_in,
  input wire break_pkg::cpu_out_type cpu_out,
  input wire logic irq
);
  import break_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_req_pulse: assert property (
    cpu_out.breakpoint_request |=> !cpu_out.breakpoint_request) else $error("long request");
  chk_req_entry: assert property (
    cpu_out.breakpoint_request |-> cpu_out.in_break && !$past(cpu_out.in_break))
    else $error("request without break entry");
  chk_timer_halt: assert property (
    cpu_out.timer_halt == cpu_out.in_break) else $error("timer halt differs from break");
  chk_vector_mode: assert property (
    cpu_out.in_break |-> cpu_out.break_vector ==
    ($past(cpu_in.monitor_mode) ? vector_monitor : vector_normal)) else $error("bad vector");
  chk_watchdog_gate: assert property (
    cpu_out.watchdog_hold |-> cpu_out.in_break && $past(cpu_in.monitor_mode))
    else $error("watchdog held outside monitor break");
  chk_flag_clear: assert property (
    !cpu_out.in_break |-> cpu_out.flag_clear_allowed) else $error("flags locked outside break");
  chk_rti_ends: assert property (
    cpu_in.rti_done && cpu_out.in_break |=> !cpu_out.in_break) else $error("break kept");
  chk_sleep_quiet: assert property (
    (cpu_in.wait_mode || cpu_in.stop_mode) && !cpu_in.instr_start |=>
    !cpu_out.breakpoint_request) else $error("break in wait or stop");
endmodule
bind address_breakpoint_unit address_breakpoint_unit_properties i_props (.ref_clk(ref_clk),
  .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .cpu_in(cpu_in), .cpu_out(cpu_out),
  .irq(irq));
`default_nettype wire

// >>> verification/cpu_side_model.sv
// CPU model: three-cycle instructions (start, opcode, operand) and a timed break routine
// Assumes ctl is {wait exit, monitor, stop, wait}, driven by the bench
`timescale 1ns/100ps
`default_nettype none
module cpu_side_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [15:0] load_pc,
  input wire logic [3:0] ctl,
  input wire logic slow,
  input wire break_pkg::cpu_out_type cpu_out,
  output var break_pkg::cpu_in_type cpu_in
);
  import break_pkg::*;
  logic [15:0] pc_reg;
  logic [1:0] phase_reg;
  logic [4:0] count_reg;
  logic run;
  assign run = !cpu_out.in_break && ctl[1:0] == 2'h0;
  always_comb
  begin
    cpu_in = '0;
    cpu_in.addr = cpu_out.in_break ? cpu_out.break_vector + 16'(count_reg)
      : pc_reg + 16'(phase_reg[1]);
    cpu_in.opcode_fetch = run && phase_reg == 2'h1;
    cpu_in.instr_start = run && phase_reg == 2'h0;
    // Routine returns promptly or slowly
    cpu_in.rti_done = cpu_out.in_break && count_reg == (slow ? 5'h14 : 5'h0a);
    {cpu_in.wait_exit_break, cpu_in.monitor_mode, cpu_in.stop_mode, cpu_in.wait_mode} = ctl;
  end
  always_ff @(posedge ref_clk)
  begin
    count_reg <= (rst || !cpu_out.in_break) ? 5'h00 : count_reg + 5'h01;
    if (rst || load)
    begin
      pc_reg <= rst ? 16'h0000 : load_pc;
      phase_reg <= 2'h0;
    end
    else if (run)
    begin
      // The broken instruction stalls until the routine returns
      phase_reg <= phase_reg == 2'h2 ? 2'h0 : phase_reg + 2'h1;
      pc_reg <= phase_reg == 2'h2 ? pc_reg + 16'h0002 : pc_reg;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the breakpoint unit with the CPU model
// Assumes the package offsets and a 40 ns clock
`timescale 1ns/100ps
`default_nettype none
module tb;
  import break_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  reg_req_type req = '0;
  logic [7:0] rdata;
  cpu_in_type cpu_in;
  cpu_out_type cpu_out;
  logic irq;
  logic load = 1'b0;
  logic [15:0] target = 16'h0000;
  logic [3:0] ctl = 4'h0;
  logic slow = 1'b0;
  integer seed = 55716;
  int mismatches = 0;
  int checks = 0;
  always #20 ref_clk = ~ref_clk;
  address_breakpoint_unit i_address_breakpoint_unit (.ref_clk(ref_clk), .rst(rst),
    .reg_req(req), .reg_rdata(rdata), .cpu_in(cpu_in), .cpu_out(cpu_out), .irq(irq));
  cpu_side_model i_cpu_side_model (.ref_clk(ref_clk), .rst(rst), .load(load),
    .load_pc(target), .ctl(ctl), .slow(slow), .cpu_out(cpu_out), .cpu_in(cpu_in));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk) req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk) req <= '0;
    #1 chk("register", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic jump();
    @(posedge ref_clk) load <= 1'b1;
    @(posedge ref_clk) load <= 1'b0;
  endtask
  task automatic await(input string n, input logic idle, input logic e);
    logic got = 1'b0;
    for (int i = 0; i < 40 && got !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #1 got = idle ? !cpu_out.in_break : cpu_out.breakpoint_request;
    end
    chk(n, 16'(e), 16'(got));
    if (e && got !== 1'b1)
      print_verdict();
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk("vector", vector_normal, cpu_out.break_vector);
    for (int a = 0; a < 8; a++) rd(3'(a), byte_reset);
    $display("test reset done");
    wr(addr_irq_mask, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      target = 16'($random(seed)) & 16'hfffe;
      slow <= i[1];
      wr(addr_address_high, target[7:0]);
      wr(addr_address_high, target[15:8]);
      wr(addr_address_low, target[7:0] | 8'(i[0]));
      wr(addr_control_status, 8'h80);
      jump();
      await("break", 1'b0, 1'b1);
      chk("halt", 16'h0001, 16'(cpu_out.timer_halt));
      chk("flag clear", 16'h0000, 16'(cpu_out.flag_clear_allowed));
      chk("irq", 16'h0001, 16'(irq));
      rd(addr_control_status, 8'hc0);
      rd(addr_irq_status, 8'h01);
      rd(addr_irq_status, 8'h00);
      wr(addr_control_status, 8'h80);
      await("return", 1'b1, 1'b1);
      jump();
      await("repeat", 1'b0, 1'b0);
      $display("test break %0d done", i);
    end
    @(posedge ref_clk) ctl <= 4'h4;
    wr(addr_auxiliary, 8'h01);
    wr(addr_flag_control, 8'h80);
    wr(addr_control_status, 8'h40);
    await("forced", 1'b0, 1'b1);
    chk("vector", vector_monitor, cpu_out.break_vector);
    chk("watchdog", 16'h0001, 16'(cpu_out.watchdog_hold));
    chk("flag clear", 16'h0001, 16'(cpu_out.flag_clear_allowed));
    @(posedge ref_clk) ctl <= 4'hc;
    @(posedge ref_clk) ctl <= 4'h4;
    rd(addr_wait_status, 8'h02);
    rd(addr_irq_status, 8'h02);
    wr(addr_control_status, 8'h00);
    await("return", 1'b1, 1'b1);
    $display("test forced done");
    @(posedge ref_clk) ctl <= 4'h1;
    wr(addr_address_low, target[7:0]);
    wr(addr_control_status, 8'h80);
    jump();
    await("sleep", 1'b0, 1'b0);
    @(posedge ref_clk) ctl <= 4'h0;
    await("wake", 1'b0, 1'b1);
    wr(addr_control_status, 8'h00);
    await("return", 1'b1, 1'b1);
    $display("test sleep done");
    print_verdict();
  end
endmodule
`default_nettype wire
